/* File: hw/qit_top.sv */
// Function
// [RULE1] Rising edge of timer zero output raises the tick interrupt; timer zero has no pin.
// [RULE2] Rising edge of timer one output requests refresh when enabled; off after reset.
// [RULE3] Timer two pin is open-collector; low level raises shared interrupt when enabled.
// [RULE4] Timer three output passes an edge detector that raises its interrupt on rising edges.
// [RULE5] Timer two and three pins show the inverse of their counter outputs.
// [RULE6] Two write-only control words: first for timers 0-2, second for timer 3.
// [RULE7] Each core is a 16-bit presettable down counter, reached only through latches.
// [RULE8] Output latches follow the core; a latch command freezes them until read.
// [RULE9] Only one latch byte at a time drives the byte-wide read path.
// [RULE10] Preset bytes are written one at a time, loaded into the core together.
// [RULE11] Writing a control word clears both preset bytes.
// [RULE12] All four counters share one timebase but run independent modes.
// [RULE13] Gate sampled on timebase rising edge; load and count on falling edge.
// [RULE14] Gates of timers 0 and 1 stay high; timers 2 and 3 use port bits 0 and 6.
// [RULE15] Reset leaves the gates of timers two and three low.
// [RULE16] Latched status holds control word, output state and null-count flag.
// [RULE17] Per mode, the gate acts as count enable level or as start trigger.
// [RULE18] Software writes a control word first, then the initial count.
// [RULE19] Gate port bits are readable and writable; changes apply at next gate sample.
// [RULE20] The timebase input passes a synchroniser before the counters use its edges.
//
// Implementation choice: the AHB-Lite slave port.
module qit_top (
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic timer_timebase_in,
	output logic timer_one_pin,
	input wire logic timer_two_pin_n_in,
	output logic timer_two_pin_n_out,
	output logic timer_two_pin_n_oe,
	output logic timer_three_pin_n,
	output logic tick_interrupt_line,
	output logic timer_three_interrupt_line,
	output logic shared_pin_interrupt_line_n,
	output logic refresh_request
);

	localparam int unsigned N = qit_pkg::NUM_TIMERS;

	qit_pkg::qit_bus_state_type bus_state, next_bus_state;
	logic [qit_pkg::IDX_W-1:0] ph_idx, next_ph_idx;
	logic ph_mapped, next_ph_mapped;
	logic [31:0] next_hrdata;
	logic [1:0] gate_port, next_gate_port;
	logic [1:0] func, next_func;
	logic tb_meta, tb_sync, tb_prev;
	logic rise_en, fall_en;
	logic [N-1:0] out_bus, out_prev, gate_bus;
	logic [7:0] rd_bytes [N];
	qit_pkg::qit_cmd_type cmd_bus [N];
	logic accept;
	logic [7:0] wbyte;
	logic next_tick, next_t3_irq, next_refresh, next_shared_n, next_pin1, next_pin3;

	assign hresp = 1'b0;
	assign timer_two_pin_n_out = 1'b0;
	assign wbyte = hwdata[7:0];
	assign hreadyout = (bus_state != qit_pkg::BUS_READ_WAIT);
	assign accept = hsel && hready && htrans[1];

	// The timebase may be unrelated to core_clk, so it is resynchronised and its edges become enables.
	always_ff @(posedge core_clk)
	begin
		if (!reset_n)
		begin
			tb_meta <= 1'b0;
			tb_sync <= 1'b0;
			tb_prev <= 1'b0;
		end
		else
		begin
			tb_meta <= timer_timebase_in; // RULE20
			tb_sync <= tb_meta;
			tb_prev <= tb_sync;
		end
	end
	assign rise_en = tb_sync && !tb_prev; // RULE13
	assign fall_en = !tb_sync && tb_prev; // RULE13

	// Timers zero and one have their gates tied high.
	assign gate_bus = {gate_port[1], gate_port[0], 1'b1, 1'b1}; // RULE14

	genvar gi;
	generate
		for (gi = 0; gi < N; gi++)
		begin : g_timer
			// One shared timebase enable pair drives every counter.
			qit_counter #(
				.COUNT_W(qit_pkg::COUNT_W)
			) u_counter (
				.core_clk(core_clk),
				.reset_n(reset_n),
				.rise_en(rise_en), // RULE12
				.fall_en(fall_en),
				.gate(gate_bus[gi]),
				.cmd(cmd_bus[gi]),
				.rd_byte(rd_bytes[gi]),
				.out(out_bus[gi])
			); // RULE7
		end
	endgenerate

	// Commands are decoded in the data phase, when hwdata is valid.
	always_comb
	begin
		for (int i = 0; i < N; i++)
		begin
			cmd_bus[i] = '0;
			cmd_bus[i].wdata = wbyte;
		end
		next_gate_port = gate_port;
		next_func = func;
		if (bus_state == qit_pkg::BUS_WRITE && ph_mapped)
		begin
			for (int i = 0; i < N; i++)
				if (ph_idx == qit_pkg::IDX_COUNT0 + qit_pkg::IDX_W'(i))
					cmd_bus[i].count_wr = 1'b1; // RULE10
			if (ph_idx == qit_pkg::IDX_CTRL_WORD1) // RULE6
			begin
				if (wbyte[qit_pkg::CW_SEL_HI:qit_pkg::CW_SEL_LO] == qit_pkg::SEL_READBACK)
				begin
					for (int i = 0; i < N - 1; i++)
					begin
						cmd_bus[i].latch_count = wbyte[i + 1] && !wbyte[qit_pkg::RB_NO_COUNT_BIT];
						cmd_bus[i].latch_status = wbyte[i + 1] && !wbyte[qit_pkg::RB_NO_STATUS_BIT]; // RULE16
					end
				end
				else
				begin
					for (int i = 0; i < N - 1; i++)
						if (wbyte[qit_pkg::CW_SEL_HI:qit_pkg::CW_SEL_LO] == 2'(i))
						begin
							cmd_bus[i].latch_count = (wbyte[qit_pkg::CW_RW_HI:qit_pkg::CW_RW_LO] == qit_pkg::RW_LATCH);
							cmd_bus[i].cw_wr = (wbyte[qit_pkg::CW_RW_HI:qit_pkg::CW_RW_LO] != qit_pkg::RW_LATCH);
						end
				end
			end
			if (ph_idx == qit_pkg::IDX_CTRL_WORD2) // RULE6
			begin
				if (wbyte[qit_pkg::CW_SEL_HI:qit_pkg::CW_SEL_LO] == qit_pkg::SEL_READBACK)
				begin
					cmd_bus[N-1].latch_count = wbyte[qit_pkg::RB_TIMER3_BIT] && !wbyte[qit_pkg::RB_NO_COUNT_BIT];
					cmd_bus[N-1].latch_status = wbyte[qit_pkg::RB_TIMER3_BIT] && !wbyte[qit_pkg::RB_NO_STATUS_BIT];
				end
				else
				begin
					cmd_bus[N-1].latch_count = (wbyte[qit_pkg::CW_RW_HI:qit_pkg::CW_RW_LO] == qit_pkg::RW_LATCH);
					cmd_bus[N-1].cw_wr = (wbyte[qit_pkg::CW_RW_HI:qit_pkg::CW_RW_LO] != qit_pkg::RW_LATCH);
				end
			end
			if (ph_idx == qit_pkg::IDX_GATE_PORT)
				next_gate_port = {wbyte[qit_pkg::GATE3_BIT], wbyte[qit_pkg::GATE2_BIT]}; // RULE19
			if (ph_idx == qit_pkg::IDX_FUNC_CTRL)
				next_func = {wbyte[qit_pkg::FUNC_SHARED_IRQ_BIT], wbyte[qit_pkg::FUNC_REFRESH_BIT]};
		end
		if (bus_state == qit_pkg::BUS_READ_WAIT && ph_mapped)
			for (int i = 0; i < N; i++)
				if (ph_idx == qit_pkg::IDX_COUNT0 + qit_pkg::IDX_W'(i))
					cmd_bus[i].rd_pop = 1'b1; // RULE8
	end

	// Bus sequencing: writes finish with no wait state, reads insert one to register hrdata.
	always_comb
	begin
		next_bus_state = bus_state;
		next_ph_idx = ph_idx;
		next_ph_mapped = ph_mapped;
		next_hrdata = hrdata;
		case (bus_state)
			qit_pkg::BUS_IDLE, qit_pkg::BUS_WRITE, qit_pkg::BUS_READ_DONE:
			begin
				if (accept)
				begin
					next_ph_idx = haddr[qit_pkg::IDX_MSB:qit_pkg::IDX_LSB];
					next_ph_mapped = (haddr[31:qit_pkg::IDX_MSB+1] == '0);
					next_bus_state = hwrite ? qit_pkg::BUS_WRITE : qit_pkg::BUS_READ_WAIT;
				end
				else
					next_bus_state = qit_pkg::BUS_IDLE;
			end
			qit_pkg::BUS_READ_WAIT:
			begin
				next_hrdata = 32'h0000_0000;
				if (ph_mapped)
				begin
					for (int i = 0; i < N; i++)
						if (ph_idx == qit_pkg::IDX_COUNT0 + qit_pkg::IDX_W'(i))
							next_hrdata[7:0] = rd_bytes[i]; // RULE9
					if (ph_idx == qit_pkg::IDX_GATE_PORT)
					begin
						next_hrdata[qit_pkg::GATE2_BIT] = gate_port[0]; // RULE19
						next_hrdata[qit_pkg::GATE3_BIT] = gate_port[1];
					end
					if (ph_idx == qit_pkg::IDX_FUNC_CTRL)
					begin
						next_hrdata[qit_pkg::FUNC_REFRESH_BIT] = func[0];
						next_hrdata[qit_pkg::FUNC_SHARED_IRQ_BIT] = func[1];
					end
					if (ph_idx == qit_pkg::IDX_OUT_STATE)
						next_hrdata[N-1:0] = out_bus;
				end
				next_bus_state = qit_pkg::BUS_READ_DONE;
			end
			default:
				next_bus_state = qit_pkg::BUS_IDLE;
		endcase
	end

	// Edge detectors and pin drivers.
	always_comb
	begin
		next_tick = out_bus[0] && !out_prev[0]; // RULE1
		next_refresh = out_bus[1] && !out_prev[1] && func[0]; // RULE2
		next_t3_irq = out_bus[3] && !out_prev[3]; // RULE4
		next_shared_n = !(func[1] && !timer_two_pin_n_in); // RULE3
		next_pin1 = out_bus[1];
		next_pin3 = !out_bus[3]; // RULE5
	end
	// Open collector: pulling low while the counter output is high gives the inverted level.
	assign timer_two_pin_n_oe = out_bus[2]; // RULE5

	always_ff @(posedge core_clk)
	begin
		if (!reset_n)
		begin
			bus_state <= qit_pkg::BUS_IDLE;
			ph_idx <= '0;
			ph_mapped <= 1'b0;
			hrdata <= 32'h0000_0000;
			gate_port <= qit_pkg::GATE_RESET; // RULE15
			func <= qit_pkg::FUNC_RESET; // RULE2
			out_prev <= '0;
			tick_interrupt_line <= 1'b0;
			refresh_request <= 1'b0;
			timer_three_interrupt_line <= 1'b0;
			shared_pin_interrupt_line_n <= 1'b1;
			timer_one_pin <= 1'b0;
			timer_three_pin_n <= 1'b1;
		end
		else
		begin
			bus_state <= next_bus_state;
			ph_idx <= next_ph_idx;
			ph_mapped <= next_ph_mapped;
			hrdata <= next_hrdata;
			gate_port <= next_gate_port;
			func <= next_func;
			out_prev <= out_bus;
			tick_interrupt_line <= next_tick;
			refresh_request <= next_refresh;
			timer_three_interrupt_line <= next_t3_irq;
			shared_pin_interrupt_line_n <= next_shared_n;
			timer_one_pin <= next_pin1;
			timer_three_pin_n <= next_pin3;
		end
	end

	tick_irq_a: assert property (@(posedge core_clk) disable iff (!reset_n) // RULE1
		$rose(out_bus[0]) |=> tick_interrupt_line)
		else $error("timer zero edge gave no tick interrupt");
	refresh_req_a: assert property (@(posedge core_clk) disable iff (!reset_n) // RULE2
		$rose(out_bus[1]) |=> refresh_request == $past(func[0]))
		else $error("refresh request wrong on timer one edge");
	shared_irq_a: assert property (@(posedge core_clk) disable iff (!reset_n) // RULE3
		func[1] && !timer_two_pin_n_in |=> !shared_pin_interrupt_line_n)
		else $error("low shared pin gave no interrupt");
	t3_edge_a: assert property (@(posedge core_clk) disable iff (!reset_n) // RULE4
		timer_three_interrupt_line |-> $past(out_bus[3]) && !$past(out_bus[3], 2))
		else $error("timer three interrupt without rising edge");
	pin_invert_a: assert property (@(posedge core_clk) disable iff (!reset_n) // RULE5
		##1 timer_three_pin_n != $past(out_bus[3]))
		else $error("timer three pin not inverted");
	oc_drive_a: assert property (@(posedge core_clk) disable iff (!reset_n) // RULE5
		timer_two_pin_n_oe == out_bus[2] && !timer_two_pin_n_out)
		else $error("timer two pin drive wrong");
	gate_reset_a: assert property (@(posedge core_clk) disable iff (!reset_n) // RULE15
		$rose(reset_n) |-> gate_port == qit_pkg::GATE_RESET)
		else $error("gates not low after reset");
	gate_write_a: assert property (@(posedge core_clk) disable iff (!reset_n) // RULE19
		bus_state == qit_pkg::BUS_WRITE && ph_mapped && ph_idx == qit_pkg::IDX_GATE_PORT
		|=> gate_port[1] == $past(hwdata[qit_pkg::GATE3_BIT]) && gate_port[0] == $past(hwdata[qit_pkg::GATE2_BIT]))
		else $error("gate port write lost");
	read_wait_a: assert property (@(posedge core_clk) disable iff (!reset_n) // RULE9
		hreadyout && accept && !hwrite |=> !hreadyout ##1 hreadyout)
		else $error("read not answered after one wait state");

	tick_cover_c: cover property (@(posedge core_clk) disable iff (!reset_n) tick_interrupt_line);
	refresh_cover_c: cover property (@(posedge core_clk) disable iff (!reset_n) refresh_request);
	shared_cover_c: cover property (@(posedge core_clk) disable iff (!reset_n) !shared_pin_interrupt_line_n);
	t3_cover_c: cover property (@(posedge core_clk) disable iff (!reset_n) timer_three_interrupt_line);

endmodule : qit_top

/* File: hw/qit_pkg.sv */
package qit_pkg;

	localparam int unsigned NUM_TIMERS = 4;
	localparam int unsigned COUNT_W = 16;
	localparam int unsigned BYTE_W = 8;
	localparam int unsigned IDX_W = 10;

	// Word indices; the byte address of each register is four times its index.
	localparam logic [IDX_W-1:0] IDX_COUNT0 = 10'h040;
	localparam logic [IDX_W-1:0] IDX_CTRL_WORD1 = 10'h044;
	localparam logic [IDX_W-1:0] IDX_CTRL_WORD2 = 10'h048;
	localparam logic [IDX_W-1:0] IDX_GATE_PORT = 10'h061;
	localparam logic [IDX_W-1:0] IDX_FUNC_CTRL = 10'h062;
	localparam logic [IDX_W-1:0] IDX_OUT_STATE = 10'h063;
	localparam int unsigned IDX_LSB = 2;
	localparam int unsigned IDX_MSB = 11;

	// Gate port bits for timers two and three.
	localparam int unsigned GATE2_BIT = 0;
	localparam int unsigned GATE3_BIT = 6;
	localparam logic [1:0] GATE_RESET = 2'h0;

	// Function control: refresh request enable and shared pin interrupt enable.
	localparam int unsigned FUNC_REFRESH_BIT = 0;
	localparam int unsigned FUNC_SHARED_IRQ_BIT = 1;
	localparam logic [1:0] FUNC_RESET = 2'h0;

	// Control word fields.
	localparam int unsigned CW_SEL_HI = 7;
	localparam int unsigned CW_SEL_LO = 6;
	localparam int unsigned CW_RW_HI = 5;
	localparam int unsigned CW_RW_LO = 4;
	localparam int unsigned CW_MODE_HI = 3;
	localparam int unsigned CW_MODE_LO = 1;
	localparam int unsigned RB_NO_COUNT_BIT = 5;
	localparam int unsigned RB_NO_STATUS_BIT = 4;
	localparam int unsigned RB_TIMER3_BIT = 1;
	localparam logic [1:0] SEL_READBACK = 2'h3;
	localparam logic [1:0] RW_LATCH = 2'h0;
	localparam logic [1:0] RW_LOW = 2'h1;
	localparam logic [1:0] RW_HIGH = 2'h2;
	localparam logic [1:0] RW_BOTH = 2'h3;
	localparam logic [5:0] CW_RESET = 6'h00;

	typedef enum logic [2:0] {
		MODE_TC = 3'b000,
		MODE_ONESHOT = 3'b001,
		MODE_RATE = 3'b010,
		MODE_SQUARE = 3'b011,
		MODE_SW_STROBE = 3'b100,
		MODE_HW_STROBE = 3'b101
	} qit_mode_type;

	typedef enum logic [1:0] {
		BUS_IDLE = 2'b00,
		BUS_WRITE = 2'b01,
		BUS_READ_WAIT = 2'b10,
		BUS_READ_DONE = 2'b11
	} qit_bus_state_type;

	typedef struct packed {
		logic cw_wr;
		logic count_wr;
		logic latch_count;
		logic latch_status;
		logic rd_pop;
		logic [7:0] wdata;
	} qit_cmd_type;

endpackage : qit_pkg

/* File: hw/qit_counter.sv */
module qit_counter #(
	parameter int unsigned COUNT_W = qit_pkg::COUNT_W
) (
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic rise_en,
	input wire logic fall_en,
	input wire logic gate,
	input wire qit_pkg::qit_cmd_type cmd,
	output logic [7:0] rd_byte,
	output logic out
);

	localparam logic [COUNT_W-1:0] ONE = COUNT_W'(1);
	localparam logic [COUNT_W-1:0] TWO = COUNT_W'(2);

	function automatic qit_pkg::qit_mode_type decode_mode(input logic [2:0] m);
		case (m)
			3'b110: decode_mode = qit_pkg::MODE_RATE;
			3'b111: decode_mode = qit_pkg::MODE_SQUARE;
			default: decode_mode = qit_pkg::qit_mode_type'(m);
		endcase
	endfunction : decode_mode

	logic [5:0] cw, next_cw;
	logic [7:0] cr_hi, next_cr_hi, cr_lo, next_cr_lo;
	logic [COUNT_W-1:0] ce, next_ce, ol, next_ol;
	logic [7:0] status, next_status;
	logic latched, next_latched, st_latched, next_st_latched;
	logic wr_ph, next_wr_ph, rd_ph, next_rd_ph;
	logic pending, next_pending, has_count, next_has_count, null_count, next_null_count;
	logic gate_s, next_gate_s, trig, next_trig, next_out;
	logic load_now;
	logic [COUNT_W-1:0] cr_word, view;
	qit_pkg::qit_mode_type mode, new_mode;
	logic [1:0] rw;

	assign cr_word = {cr_hi, cr_lo};
	assign mode = decode_mode(cw[qit_pkg::CW_MODE_HI:qit_pkg::CW_MODE_LO]);
	assign new_mode = decode_mode(cmd.wdata[qit_pkg::CW_MODE_HI:qit_pkg::CW_MODE_LO]);
	assign rw = cw[qit_pkg::CW_RW_HI:qit_pkg::CW_RW_LO];
	// The output latches follow the core until a latch command freezes them.
	assign view = latched ? ol : ce; // RULE8
	always_comb
	begin
		rd_byte = view[7:0];
		if (st_latched)
			rd_byte = status;
		else if (rw == qit_pkg::RW_HIGH || (rw == qit_pkg::RW_BOTH && rd_ph))
			rd_byte = view[15:8]; // RULE9
	end

	always_comb
	begin
		next_cw = cw;
		next_cr_hi = cr_hi;
		next_cr_lo = cr_lo;
		next_ce = ce;
		next_ol = ol;
		next_status = status;
		next_latched = latched;
		next_st_latched = st_latched;
		next_wr_ph = wr_ph;
		next_rd_ph = rd_ph;
		next_pending = pending;
		next_has_count = has_count;
		next_null_count = null_count;
		next_gate_s = gate_s;
		next_trig = trig;
		next_out = out;
		load_now = 1'b0;
		if (rise_en)
		begin
			next_gate_s = gate; // RULE13
			if (gate && !gate_s)
				next_trig = 1'b1; // RULE17
			if (!gate && (mode == qit_pkg::MODE_RATE || mode == qit_pkg::MODE_SQUARE))
				next_out = 1'b1;
		end
		if (fall_en)
		begin
			next_trig = 1'b0;
			case (mode) // RULE17
				qit_pkg::MODE_TC, qit_pkg::MODE_SW_STROBE:
				begin
					load_now = pending;
					if (!pending && gate_s)
					begin
						next_ce = ce - ONE; // RULE13
						if (mode == qit_pkg::MODE_SW_STROBE)
							next_out = (ce != ONE);
						else if (ce == ONE)
							next_out = 1'b1;
					end
				end
				qit_pkg::MODE_ONESHOT, qit_pkg::MODE_HW_STROBE:
				begin
					load_now = trig && has_count;
					if (load_now && mode == qit_pkg::MODE_ONESHOT)
						next_out = 1'b0;
					else if (!load_now)
					begin
						next_ce = ce - ONE;
						if (mode == qit_pkg::MODE_HW_STROBE)
							next_out = (ce != ONE);
						else if (ce == ONE)
							next_out = 1'b1;
					end
				end
				qit_pkg::MODE_RATE:
				begin
					load_now = pending || (has_count && (trig || ce == ONE));
					if (load_now)
						next_out = 1'b1;
					else if (gate_s)
					begin
						next_ce = ce - ONE;
						next_out = (ce != TWO);
					end
				end
				qit_pkg::MODE_SQUARE:
				begin
					load_now = pending || (has_count && (trig || ce <= TWO));
					if (load_now)
						next_out = (pending || trig) ? 1'b1 : !out;
					else if (gate_s)
						next_ce = ce - TWO;
				end
				default:
				begin
					load_now = 1'b0;
				end
			endcase
			if (load_now)
			begin
				// Both preset bytes move into the core in the same step.
				next_ce = (mode == qit_pkg::MODE_SQUARE) ? {cr_word[COUNT_W-1:1], 1'b0} : cr_word; // RULE10
				next_pending = 1'b0;
				next_null_count = 1'b0;
			end
		end
		if (cmd.cw_wr)
		begin
			next_cw = cmd.wdata[5:0];
			next_cr_hi = 8'h00; // RULE11
			next_cr_lo = 8'h00; // RULE11
			next_out = (new_mode != qit_pkg::MODE_TC);
			next_pending = 1'b0;
			next_has_count = 1'b0;
			next_null_count = 1'b1;
			next_wr_ph = 1'b0;
			next_rd_ph = 1'b0;
			next_latched = 1'b0;
		end
		else if (cmd.count_wr)
		begin
			if (rw == qit_pkg::RW_HIGH)
				next_cr_hi = cmd.wdata; // RULE10
			else if (rw == qit_pkg::RW_BOTH && wr_ph)
				next_cr_hi = cmd.wdata;
			else
				next_cr_lo = cmd.wdata;
			if (rw == qit_pkg::RW_BOTH)
				next_wr_ph = !wr_ph;
			if (rw != qit_pkg::RW_BOTH || wr_ph)
			begin
				next_pending = 1'b1;
				next_has_count = 1'b1;
				next_null_count = 1'b1;
			end
			if (mode == qit_pkg::MODE_TC)
				next_out = 1'b0;
		end
		if (cmd.latch_count && !latched)
		begin
			next_ol = ce; // RULE8
			next_latched = 1'b1;
		end
		if (cmd.latch_status && !st_latched)
		begin
			next_status = {out, null_count, cw}; // RULE16
			next_st_latched = 1'b1;
		end
		if (cmd.rd_pop)
		begin
			if (st_latched)
				next_st_latched = 1'b0;
			else if (rw == qit_pkg::RW_BOTH && !rd_ph)
				next_rd_ph = 1'b1;
			else
			begin
				next_rd_ph = 1'b0;
				next_latched = 1'b0; // RULE8
			end
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (!reset_n)
		begin
			cw <= qit_pkg::CW_RESET;
			cr_hi <= 8'h00;
			cr_lo <= 8'h00;
			ce <= '0;
			ol <= '0;
			status <= 8'h00;
			latched <= 1'b0;
			st_latched <= 1'b0;
			wr_ph <= 1'b0;
			rd_ph <= 1'b0;
			pending <= 1'b0;
			has_count <= 1'b0;
			null_count <= 1'b1;
			gate_s <= 1'b0;
			trig <= 1'b0;
			out <= 1'b0;
		end
		else
		begin
			cw <= next_cw;
			cr_hi <= next_cr_hi;
			cr_lo <= next_cr_lo;
			ce <= next_ce;
			ol <= next_ol;
			status <= next_status;
			latched <= next_latched;
			st_latched <= next_st_latched;
			wr_ph <= next_wr_ph;
			rd_ph <= next_rd_ph;
			pending <= next_pending;
			has_count <= next_has_count;
			null_count <= next_null_count;
			gate_s <= next_gate_s;
			trig <= next_trig;
			out <= next_out;
		end
	end

	core_load_a: assert property (@(posedge core_clk) disable iff (!reset_n) // RULE10
		fall_en && pending && !cmd.cw_wr && mode == qit_pkg::MODE_TC |=> ce == $past(cr_word))
		else $error("preset pair not moved into core");
	cw_clear_a: assert property (@(posedge core_clk) disable iff (!reset_n) // RULE11
		cmd.cw_wr |=> cr_hi == 8'h00 && cr_lo == 8'h00)
		else $error("control word did not clear preset bytes");
	latch_hold_a: assert property (@(posedge core_clk) disable iff (!reset_n) // RULE8
		latched && !cmd.rd_pop && !cmd.cw_wr |=> latched && $stable(ol))
		else $error("latched count lost before read");
	gate_sample_a: assert property (@(posedge core_clk) disable iff (!reset_n) // RULE13
		!rise_en |=> $stable(gate_s))
		else $error("gate sampled off the timebase rising edge");
	status_cap_a: assert property (@(posedge core_clk) disable iff (!reset_n) // RULE16
		cmd.latch_status && !st_latched |=> status == {$past(out), $past(null_count), $past(cw)})
		else $error("status byte capture wrong");

endmodule : qit_counter

/* File: bench/qit_pin_partner.sv */
module qit_pin_partner (
	input wire logic pull_low,
	input wire logic design_oe,
	output logic timebase,
	output logic pin_level
);
	timeunit 1ns;
	timeprecision 1ps;
	// Free-running and unrelated in phase to core_clk, slower than a quarter of its rate.
	initial timebase = 1'b0;
	always #13.7 timebase = ~timebase;
	// Open-collector wire with a weak pull-up, so whoever pulls wins.
	assign pin_level = ~(pull_low | design_oe);
endmodule : qit_pin_partner

/* File: bench/quad_interval_timer_core_test.sv */
module quad_interval_timer_core_test;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [9:0] cw1 = qit_pkg::IDX_CTRL_WORD1;
	localparam logic [9:0] c0 = qit_pkg::IDX_COUNT0;
	localparam logic [9:0] gp = qit_pkg::IDX_GATE_PORT;
	localparam logic [9:0] fc = qit_pkg::IDX_FUNC_CTRL;
	logic core_clk = 1'b0;
	logic reset_n = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic pull_low = 1'b0;
	int fail_count = 0;
	int n_compared = 0;
	logic [31:0] rd;
	wire logic hreadyout, hresp, tb, pin, oe, p2o, t1, t3_n, tick, t3_irq, sh_n, refr;
	wire logic [31:0] hrdata;
	wire logic [3:0] evt = {sh_n, refr, t3_irq, tick};
	always #2.5 core_clk = ~core_clk;
	qit_top uut (.core_clk(core_clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
		.hresp(hresp), .hrdata(hrdata), .timer_timebase_in(tb), .timer_one_pin(t1),
		.timer_two_pin_n_in(pin), .timer_two_pin_n_out(p2o), .timer_two_pin_n_oe(oe),
		.timer_three_pin_n(t3_n), .tick_interrupt_line(tick), .timer_three_interrupt_line(t3_irq),
		.shared_pin_interrupt_line_n(sh_n), .refresh_request(refr));
	qit_pin_partner far_end (.pull_low(pull_low), .design_oe(oe), .timebase(tb), .pin_level(pin));
	task results;
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : results
	task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp)
		begin
			$display("BAD %s expected %h seen %h", what, exp, got);
			fail_count++;
		end
	endtask : chk
	task guard(inout int i);
		i++;
		if (i > 400)
		begin
			chk("timeout", 32'h0, 32'h1);
			results;
		end
	endtask : guard
	task bus(input logic w, input logic [9:0] idx, input logic [7:0] d);
		int i;
		i = 0;
		@(posedge core_clk);
		hsel <= 1'b1;
		haddr <= {20'h0, idx, 2'h0};
		hwrite <= w;
		htrans <= 2'h2;
		@(posedge core_clk);
		while (hreadyout !== 1'b1)
		begin
			guard(i);
			@(posedge core_clk);
		end
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= {24'h0, d};
		@(posedge core_clk);
		while (hreadyout !== 1'b1)
		begin
			guard(i);
			@(posedge core_clk);
		end
		rd = hrdata;
	endtask : bus
	task wait_lvl(input int k, input logic v);
		int i;
		i = 0;
		while (evt[k] !== v)
		begin
			guard(i);
			@(posedge core_clk);
		end
		chk("event", {31'h0, v}, {31'h0, evt[k]});
	endtask : wait_lvl
	task latch2(output logic [15:0] v);
		bus(1'b1, cw1, 8'h80);
		bus(1'b0, c0 + 10'h2, 8'h0);
		v[7:0] = rd[7:0];
		bus(1'b0, c0 + 10'h2, 8'h0);
		v[15:8] = rd[7:0];
	endtask : latch2
	task t_reset;
		chk("idle", 32'h150, {23'h0, hreadyout, hresp, t3_n, oe, sh_n, tick, t3_irq, refr, t1});
		bus(1'b0, gp, 8'h0);
		chk("gate port", 32'h0, rd);
		bus(1'b0, fc, 8'h0);
		chk("function", 32'h0, rd);
		bus(1'b1, cw1, 8'h14);
		bus(1'b0, cw1, 8'h0);
		chk("control word", 32'h0, rd);
		bus(1'b0, 10'h3ff, 8'h0);
		chk("unmapped", 32'h0, rd);
		$display("reset test done");
	endtask : t_reset
	task t_shared;
		bus(1'b1, fc, 8'h02);
		pull_low <= 1'b1;
		wait_lvl(3, 1'b0);
		pull_low <= 1'b0;
		wait_lvl(3, 1'b1);
		$display("shared pin test done");
	endtask : t_shared
	task t_events;
		bus(1'b1, cw1, 8'h14);
		bus(1'b1, c0, 8'h03);
		wait_lvl(0, 1'b1);
		wait_lvl(0, 1'b0);
		// Control word 8'h14 sets rate generator mode, which reloads at a count of one, so a second edge comes without a new count.
		bus(1'b1, c0, 8'h03);
		wait_lvl(0, 1'b1);
		bus(1'b1, fc, 8'h01);
		bus(1'b1, cw1, 8'h54);
		bus(1'b1, c0 + 10'h1, 8'h03);
		wait_lvl(2, 1'b1);
		chk("pin one", 32'h1, {31'h0, t1});
		bus(1'b1, gp, 8'h40);
		bus(1'b0, gp, 8'h0);
		chk("gate port", 32'h40, rd);
		bus(1'b1, qit_pkg::IDX_CTRL_WORD2, 8'h14);
		bus(1'b1, c0 + 10'h3, 8'h03);
		wait_lvl(1, 1'b1);
		chk("pin three", 32'h0, {31'h0, t3_n});
		$display("event test done");
	endtask : t_events
	task t_latch;
		logic [15:0] v;
		int i;
		v = 16'h0;
		i = 0;
		bus(1'b1, cw1, 8'hb0);
		bus(1'b1, c0 + 10'h2, 8'h34);
		bus(1'b1, c0 + 10'h2, 8'h12);
		while (v !== 16'h1234 && i < 20)
		begin
			latch2(v);
			i++;
		end
		chk("count", 32'h1234, {16'h0, v});
		chk("pin two drive", 32'h0, {30'h0, oe, p2o});
		bus(1'b1, cw1, 8'he8);
		bus(1'b0, c0 + 10'h2, 8'h0);
		chk("status", 32'h30, {24'h0, rd[7:0]});
		bus(1'b1, gp, 8'h41);
		repeat (40) @(posedge core_clk);
		latch2(v);
		chk("counting", 32'h1, {31'h0, v < 16'h1234});
		$display("latch test done");
	endtask : t_latch
	initial
	begin
		repeat (16) @(posedge core_clk);
		reset_n <= 1'b1;
		t_reset;
		t_shared;
		t_events;
		t_latch;
		results;
	end
endmodule : quad_interval_timer_core_test
